// file: hdl/ecct_pkg.sv
// Package of constants and types for the edge-clear capture/compare timer
package ecct_pkg;
   localparam int CNT_W = 16;
   localparam int DIV_W = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   // Register byte offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_CAPCTL = 5'h04;
   localparam logic [4:0] OFS_OUTCTL = 5'h08;
   localparam logic [4:0] OFS_PRESC = 5'h0c;
   localparam logic [4:0] OFS_COUNT = 5'h10;
   localparam logic [4:0] OFS_FIRST = 5'h14;
   localparam logic [4:0] OFS_SECOND = 5'h18;
   // Field positions
   localparam int MODE_TOC_BIT = 1;
   localparam int MODE_OP_LSB = 2;
   localparam int CAP_FIRST_BIT = 0;
   localparam int CAP_REV_BIT = 1;
   localparam int CAP_SECOND_BIT = 2;
   localparam int OUT_EN_BIT = 0;
   localparam int OUT_INV1_BIT = 1;
   localparam int OUT_INV2_BIT = 2;
   localparam int PRE_PRI_LSB = 0;
   localparam int PRE_SEC_LSB = 2;
   localparam int PRE_CLK_LSB = 4;
   // Reset values
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [2:0] CAPCTL_RST = 3'h0;
   localparam logic [2:0] OUTCTL_RST = 3'h0;
   localparam logic [5:0] PRESC_RST = 6'h00;
   // Operating modes
   localparam logic [1:0] OP_STOP = 2'h0;
   localparam logic [1:0] OP_FREE = 2'h1;
   localparam logic [1:0] OP_CLR_EDGE = 2'h2;
   // Edge selections
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Qualified edge pulses of one trigger input
   typedef struct packed {
      logic rise;
      logic fall;
   } ecct_edge_t;
endpackage

// file: hdl/ecct_edge_det.sv
// Trigger input synchroniser and two-sample edge qualifier
`timescale 1ns/100ps
module ecct_edge_det
   import ecct_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Pin and qualified edges
   input wire logic pin_i,
   output ecct_edge_t edge_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      ecct_edge_t ev;
   } ecct_det_t;

   ecct_det_t state_ff;
   ecct_det_t nxt_state;

   // Level accepted only when two samples agree, rejecting short noise
   always_comb begin
      nxt_state = state_ff;
      nxt_state.s1 = pin_i;
      nxt_state.s2 = state_ff.s1;
      nxt_state.s3 = state_ff.s2;
      nxt_state.ev = '0;
      if (state_ff.s2 == state_ff.s3) begin
         nxt_state.lvl = state_ff.s3;
         nxt_state.ev.rise = state_ff.s3 & ~state_ff.lvl;
         nxt_state.ev.fall = ~state_ff.s3 & state_ff.lvl;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign edge_o = state_ff.ev;
endmodule

// file: hdl/ecct_capcmp.sv
// One capture/compare register with write, capture and match
`timescale 1ns/100ps
module ecct_capcmp
   import ecct_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Software write, already byte-merged
   input wire logic wr_i,
   input wire logic [CNT_W-1:0] wr_data_i,
   // Hardware capture
   input wire logic cap_i,
   input wire logic [CNT_W-1:0] cap_data_i,
   // Compare against the counter's next value
   input wire logic upd_i,
   input wire logic [CNT_W-1:0] nxt_count_i,
   output logic match_o,
   output logic [CNT_W-1:0] value_o
);
   typedef struct packed {
      logic [CNT_W-1:0] value;
   } ecct_cc_t;

   ecct_cc_t state_ff;
   ecct_cc_t nxt_state;

   // Capture wins over a software write in the same cycle
   always_comb begin
      nxt_state = state_ff;
      if (cap_i) begin
         nxt_state.value = cap_data_i;
      end else if (wr_i) begin
         nxt_state.value = wr_data_i;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign match_o = upd_i & (nxt_count_i == state_ff.value);
   assign value_o = state_ff.value;
endmodule

// file: hdl/ecct_timer.sv
// Edge-clear capture/compare timer with Avalon-MM register slave
`timescale 1ns/100ps
module ecct_timer
   import ecct_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Trigger pins
   input wire logic trig_in_primary_i,
   input wire logic trig_in_secondary_i,
   // Toggle pin and interrupts
   output logic toggle_out_o,
   output logic irq_first_o,
   output logic irq_second_o
);
   typedef struct packed {
      logic [3:0] mode;
      logic [2:0] capctl;
      logic [2:0] outctl;
      logic [5:0] presc;
      logic [CNT_W-1:0] count;
      logic [DIV_W-1:0] div;
      logic tog;
      logic hit1;
      logic hit2;
      logic irq_first;
      logic irq_second;
      logic ack;
      logic [31:0] rdata;
   } ecct_state_t;

   ecct_state_t state_ff;
   ecct_state_t nxt_state;

   ecct_edge_t pri_edge;
   ecct_edge_t sec_edge;
   logic [CNT_W-1:0] first_val;
   logic [CNT_W-1:0] second_val;
   logic match1;
   logic match2;
   logic [CNT_W-1:0] nxt_count;
   logic upd;
   logic run;
   logic tick;
   logic clr_cause;
   logic pri_valid;
   logic pri_rev;
   logic sec_valid;
   logic cap1;
   logic cap2;
   logic first_cap;
   logic second_cap;
   logic rev_sel;
   logic inv;
   logic [1:0] op_mode;
   logic bus_req;
   logic wr_first;
   logic wr_second;
   logic [31:0] rd_mux;

   // Edge hit for a two-bit edge selection
   function automatic logic edge_hit(input ecct_edge_t e, input logic [1:0] sel);
      logic hit;
      hit = 1'b0;
      case (sel)
         EDGE_FALL: hit = e.fall;
         EDGE_RISE: hit = e.rise;
         EDGE_BOTH: hit = e.rise | e.fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Opposite phase of a selection; both edges stay both edges
   function automatic logic [1:0] edge_flip(input logic [1:0] sel);
      logic [1:0] r;
      r = sel;
      if (sel == EDGE_RISE) begin
         r = EDGE_FALL;
      end else if (sel == EDGE_FALL) begin
         r = EDGE_RISE;
      end
      return r;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [CNT_W-1:0] be_merge(input logic [CNT_W-1:0] old,
         input logic [31:0] wd, input logic [3:0] be);
      logic [CNT_W-1:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Trigger input qualifiers
   ecct_edge_det u_pri_det (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pin_i(trig_in_primary_i),
      .edge_o(pri_edge)
   );

   ecct_edge_det u_sec_det (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pin_i(trig_in_secondary_i),
      .edge_o(sec_edge)
   );

   // Capture/compare registers
   ecct_capcmp u_capcmp_first (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_i(wr_first),
      .wr_data_i(be_merge(first_val, avs_writedata_i, avs_byteenable_i)),
      .cap_i(cap1),
      .cap_data_i(state_ff.count),
      .upd_i(upd),
      .nxt_count_i(nxt_count),
      .match_o(match1),
      .value_o(first_val)
   );

   ecct_capcmp u_capcmp_second (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_i(wr_second),
      .wr_data_i(be_merge(second_val, avs_writedata_i, avs_byteenable_i)),
      .cap_i(cap2),
      .cap_data_i(state_ff.count),
      .upd_i(upd),
      .nxt_count_i(nxt_count),
      .match_o(match2),
      .value_o(second_val)
   );

   // Control decode
   assign op_mode = state_ff.mode[MODE_OP_LSB +: 2];
   assign run = (op_mode != OP_STOP);
   assign first_cap = state_ff.capctl[CAP_FIRST_BIT];
   assign second_cap = state_ff.capctl[CAP_SECOND_BIT];
   assign rev_sel = state_ff.capctl[CAP_REV_BIT] & first_cap;

   // Count clock: one tick per 2^sel reference clocks
   assign tick = run
      & ((state_ff.div & DIV_W'((1 << state_ff.presc[PRE_CLK_LSB +: 2]) - 1)) == '0);

   // Qualified trigger events, ignored while stopped
   assign pri_valid = run & edge_hit(pri_edge, state_ff.presc[PRE_PRI_LSB +: 2]);
   assign pri_rev = run & edge_hit(pri_edge, edge_flip(state_ff.presc[PRE_PRI_LSB +: 2]));
   assign sec_valid = run & edge_hit(sec_edge, state_ff.presc[PRE_SEC_LSB +: 2]);

   // Primary edge clears only in clear-and-start mode
   assign clr_cause = (op_mode == OP_CLR_EDGE) & pri_valid;

   // Next count: stop initialises, clear beats a tick, plain wrap otherwise
   always_comb begin
      nxt_count = state_ff.count;
      if (!run) begin
         nxt_count = CNT_ZERO;
      end else if (clr_cause) begin
         nxt_count = CNT_ZERO;
      end else if (tick) begin
         nxt_count = state_ff.count + CNT_ONE;
      end
   end
   assign upd = run & (clr_cause | tick);

   // Captures: second on primary edge, first on secondary or opposite phase
   assign cap2 = second_cap & pri_valid;
   assign cap1 = first_cap & (rev_sel ? pri_rev : sec_valid);

   // Toggle causes; compare hits act one cycle after the count reaches the value
   assign inv = state_ff.hit1
      | state_ff.hit2
      | (state_ff.mode[MODE_TOC_BIT] & clr_cause);

   // Bus access strobes; one wait cycle, writes land on the edge where waitrequest is low
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & ~state_ff.ack;
   assign wr_first = avs_write_i & state_ff.ack & (avs_address_i[4:2] == OFS_FIRST[4:2]);
   assign wr_second = avs_write_i & state_ff.ack & (avs_address_i[4:2] == OFS_SECOND[4:2]);

   // Read mux; reading the counter has no side effect
   always_comb begin
      rd_mux = '0;
      case (avs_address_i[4:2])
         OFS_MODE[4:2]: rd_mux[3:0] = state_ff.mode;
         OFS_CAPCTL[4:2]: rd_mux[2:0] = state_ff.capctl;
         OFS_OUTCTL[4:2]: rd_mux[2:0] = state_ff.outctl;
         OFS_PRESC[4:2]: rd_mux[5:0] = state_ff.presc;
         OFS_COUNT[4:2]: rd_mux[CNT_W-1:0] = state_ff.count;
         OFS_FIRST[4:2]: rd_mux[CNT_W-1:0] = first_val;
         OFS_SECOND[4:2]: rd_mux[CNT_W-1:0] = second_val;
         default: rd_mux = '0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      nxt_state = state_ff;
      nxt_state.count = nxt_count;
      nxt_state.div = run ? state_ff.div + DIV_W'(1) : '0;
      // Interrupts are single-clock pulses of the effective event
      nxt_state.irq_first = run & (first_cap ? sec_valid : match1);
      nxt_state.irq_second = run & (second_cap ? pri_valid : match2);
      // Compare hits wait one cycle so the pulse spans the whole compare count when the count clock is undivided
      nxt_state.hit1 = match1 & state_ff.outctl[OUT_INV1_BIT] & ~first_cap;
      nxt_state.hit2 = match2 & state_ff.outctl[OUT_INV2_BIT] & ~second_cap;
      // Stopped output returns to its low initial level
      if (!run) begin
         nxt_state.tog = 1'b0;
      end else begin
         nxt_state.tog = state_ff.tog ^ inv;
      end
      // Bus handshake and register writes
      nxt_state.ack = bus_req & ~state_ff.ack;
      if (avs_read_i & ~state_ff.ack) begin
         nxt_state.rdata = rd_mux;
      end
      if (avs_write_i & state_ff.ack & avs_byteenable_i[0]) begin
         case (avs_address_i[4:2])
            OFS_MODE[4:2]: nxt_state.mode = avs_writedata_i[3:0];
            OFS_CAPCTL[4:2]: nxt_state.capctl = avs_writedata_i[2:0];
            OFS_OUTCTL[4:2]: nxt_state.outctl = avs_writedata_i[2:0];
            OFS_PRESC[4:2]: nxt_state.presc = avs_writedata_i[5:0];
            default: nxt_state.mode = state_ff.mode;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
         state_ff.mode <= MODE_RST;
         state_ff.capctl <= CAPCTL_RST;
         state_ff.outctl <= OUTCTL_RST;
         state_ff.presc <= PRESC_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs; pin gated by its enable
   assign toggle_out_o = state_ff.outctl[OUT_EN_BIT] & state_ff.tog;
   assign irq_first_o = state_ff.irq_first;
   assign irq_second_o = state_ff.irq_second;
   assign avs_readdata_o = state_ff.rdata;

   // Primary edge in clear mode zeroes the count next cycle
   clear_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      clr_cause |=> (state_ff.count == CNT_ZERO))
      else $error("count not cleared after primary edge");

   // Second capture holds the pre-clear count
   cap_second_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (cap2 & ~wr_second) |=> (second_val == $past(state_ff.count)) && irq_second_o)
      else $error("second capture value or interrupt wrong");

   // Compare interrupt ties to the count equal to the first value
   match_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (irq_first_o && !$past(first_cap)) |-> (state_ff.count == $past(first_val)))
      else $error("first compare interrupt without match");

   // Clear with toggle-on-clear flips the output state
   clear_toggle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clr_cause && state_ff.mode[MODE_TOC_BIT] && !(match1 && state_ff.outctl[OUT_INV1_BIT]
         && !first_cap) && !(match2 && state_ff.outctl[OUT_INV2_BIT] && !second_cap))
      |=> (state_ff.tog != $past(state_ff.tog)))
      else $error("toggle missing on clear");

   // Reverse-phase capture gives no first interrupt
   rev_noirq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rev_sel && pri_rev && !sec_valid) |=> !irq_first_o)
      else $error("interrupt raised on reverse-phase capture");

   // Secondary edge in reverse mode interrupts without capturing
   sec_nocap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rev_sel && sec_valid && !pri_rev && !wr_first) |=> irq_first_o && $stable(first_val))
      else $error("secondary edge handled wrongly in reverse mode");

   // Secondary edge captures into first when not reverse
   cap_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (first_cap && !rev_sel && sec_valid) |=> (first_val == $past(state_ff.count)) && irq_first_o)
      else $error("first capture on secondary edge failed");

   // No cause means the output state holds
   tog_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run && !inv) |=> $stable(state_ff.tog))
      else $error("output toggled without cause");

   // Wrap from all ones to zero without a clear
   wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (tick && !clr_cause && (state_ff.count == '1)) |=> (state_ff.count == CNT_ZERO))
      else $error("counter did not wrap");

   // Stop mode keeps the counter at zero
   stop_init_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !run |=> (state_ff.count == CNT_ZERO) && !irq_first_o && !irq_second_o)
      else $error("stopped counter not initialised");

   // Second interrupt in capture mode never outlives its primary edge by more than one cycle
   irq_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (irq_second_o && second_cap && !$past(pri_valid, 1)) |-> 1'b0)
      else $error("second interrupt without primary edge");

   // Counter read returns the count seen in the first cycle of the request, while waitrequest is high
   read_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (avs_read_i && !state_ff.ack && avs_address_i[4:2] == OFS_COUNT[4:2])
      |=> avs_readdata_o[CNT_W-1:0] == $past(state_ff.count))
      else $error("count read returned wrong value");

   // A pending compare hit flips the output on the next edge
   hit_toggle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run && (state_ff.hit1 || state_ff.hit2)) |=> (state_ff.tog != $past(state_ff.tog)))
      else $error("output not toggled after compare hit");

   // Clear with a zero compare value raises the first interrupt
   zero_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clr_cause && !first_cap && (first_val == CNT_ZERO)) |=> irq_first_o)
      else $error("first interrupt missing after clear to zero");

   // A qualified primary edge lasts one cycle, so each edge acts once
   edge_once_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (pri_edge.rise || pri_edge.fall) |=> !(pri_edge.rise || pri_edge.fall))
      else $error("primary edge event held longer than one cycle");

   // Mode write lands on the edge where waitrequest is low
   mode_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
         && (avs_address_i[4:2] == OFS_MODE[4:2]))
      |=> (state_ff.mode == $past(avs_writedata_i[3:0])))
      else $error("mode write did not land");
endmodule

// file: testbench/ecct_trig_model.sv
// Trigger pin model driving the primary and secondary inputs
`timescale 1ns/100ps
module ecct_trig_model (
   // Clock
   input wire logic ref_clk_i,
   // Trigger pins
   output logic trig_in_primary_o,
   output logic trig_in_secondary_o
);
   // Both pins idle low, driven push-pull at all times
   initial begin
      trig_in_primary_o = 1'b0;
      trig_in_secondary_o = 1'b0;
   end
   // Change a pin after an edge and hold it; a hold of one clock is a glitch
   task automatic drive(input logic sec, input logic lvl, input int hold);
      @(posedge ref_clk_i);
      if (sec) trig_in_secondary_o <= lvl;
      else trig_in_primary_o <= lvl;
      repeat (hold - 1) @(posedge ref_clk_i);
   endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the edge-clear capture/compare timer
`timescale 1ns/100ps
module tb_top;
   import ecct_pkg::*;
   logic clk, rst, rd, wr, waitreq, pri, sec, tog, irq1, irq2;
   logic [4:0] address;
   logic [31:0] wdata, rdata, rv, rv2;
   logic [3:0] be;
   logic [15:0] n_irq1 = 16'h0, n_irq2 = 16'h0, n_tog = 16'h0, s1, s2, st;
   logic tog_q = 1'b0;
   int cyc = 0, t_last = 0, t_prev = 0;
   int miscompares = 0;
   int comparisons = 0;

   ecct_timer ecct_timer_i (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(address),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .trig_in_primary_i(pri),
      .trig_in_secondary_i(sec), .toggle_out_o(tog), .irq_first_o(irq1), .irq_second_o(irq2));
   ecct_trig_model trig_model_i (.ref_clk_i(clk), .trig_in_primary_o(pri),
      .trig_in_secondary_o(sec));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pulse and toggle bookkeeping; interrupt counts are high cycles, so one per event
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tog_q <= tog;
      if (irq1 === 1'b1) n_irq1 <= n_irq1 + 16'h1;
      if (irq2 === 1'b1) n_irq2 <= n_irq2 + 16'h1;
      if (tog !== tog_q) begin
         n_tog <= n_tog + 16'h1;
         t_prev <= t_last;
         t_last <= cyc;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One bus access; request held until waitrequest is sampled low
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         miscompares++;
         print_verdict;
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      av(1'b1, a, d, rv);
   endtask

   task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      av(1'b0, a, 32'h0, rv);
      check(what, rv, exp);
   endtask

   task automatic pe(input logic lvl, input int h);
      trig_model_i.drive(1'b0, lvl, h);
   endtask

   task automatic se(input logic lvl, input int h);
      trig_model_i.drive(1'b1, lvl, h);
   endtask

   // Stop first so the counter and toggle restart clean, then settle and snapshot
   task automatic cfg(input logic [3:0] m, input logic [2:0] c, input logic [2:0] o,
      input logic [5:0] p, input logic [15:0] f, input logic [15:0] s);
      wreg(OFS_MODE, 32'h0);
      wreg(OFS_CAPCTL, {29'h0, c});
      wreg(OFS_OUTCTL, {29'h0, o});
      wreg(OFS_PRESC, {26'h0, p});
      wreg(OFS_FIRST, {16'h0, f});
      wreg(OFS_SECOND, {16'h0, s});
      wreg(OFS_MODE, {28'h0, m});
      repeat (10) @(posedge clk);
      s1 = n_irq1;
      s2 = n_irq2;
      st = n_tog;
   endtask

   // Watchdog beyond the wrap scenario plus the short ones, at 75000 cycles
   initial begin
      repeat (75000) @(posedge clk);
      miscompares++;
      print_verdict;
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      address = 5'h00;
      wdata = 32'h0;
      be = 4'hf;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rchk("mode", OFS_MODE, {28'h0, MODE_RST});
      rchk("capctl", OFS_CAPCTL, {29'h0, CAPCTL_RST});
      rchk("outctl", OFS_OUTCTL, {29'h0, OUTCTL_RST});
      rchk("presc", OFS_PRESC, {26'h0, PRESC_RST});
      rchk("unmapped", 5'h1c, 32'h0);
      wreg(OFS_COUNT, 32'h1234);
      rchk("count stopped", OFS_COUNT, 32'h0);
      // Second captures, first compares zero, toggle on match only
      cfg(4'h8, 3'h4, 3'h3, 6'h01, 16'h0, 16'h0);
      av(1'b0, OFS_COUNT, 32'h0, rv);
      av(1'b0, OFS_COUNT, 32'h0, rv2);
      check("count advance", rv2 - rv, 32'h3);
      pe(1'b1, 1);
      pe(1'b0, 10);
      check("glitch irq_second", n_irq2 - s2, 32'h0);
      check("toggle idle", {31'h0, tog}, 32'h0);
      pe(1'b1, 20);
      pe(1'b0, 20);
      pe(1'b1, 20);
      pe(1'b0, 20);
      check("irq_second pulses", n_irq2 - s2, 32'h2);
      check("irq_first pulses", n_irq1 - s1, 32'h2);
      check("toggles match only", n_tog - st, 32'h2);
      rchk("second capture", OFS_SECOND, 32'h27);
      // Toggle on clear plus compare three gives a short pulse
      cfg(4'ha, 3'h4, 3'h3, 6'h01, 16'h3, 16'h0);
      pe(1'b1, 20);
      pe(1'b0, 20);
      check("toggles on clear", n_tog - st, 32'h2);
      check("pulse width", t_last - t_prev, 32'h4);
      check("compare irq", n_irq1 - s1, 32'h1);
      check("capture irq", n_irq2 - s2, 32'h1);
      // Reverse-phase capture into first, secondary edge interrupts only
      cfg(4'h8, 3'h3, 3'h1, 6'h05, 16'h0, 16'hffff);
      pe(1'b1, 30);
      pe(1'b0, 20);
      check("no irq_first on reverse", n_irq1 - s1, 32'h0);
      rchk("first reverse capture", OFS_FIRST, 32'h1d);
      se(1'b1, 20);
      se(1'b0, 20);
      check("secondary irq_first", n_irq1 - s1, 32'h1);
      rchk("first untouched", OFS_FIRST, 32'h1d);
      // Both capturing, both edges on both pins
      cfg(4'ha, 3'h5, 3'h1, 6'h0f, 16'h0, 16'h0);
      pe(1'b1, 30);
      pe(1'b0, 20);
      se(1'b1, 20);
      se(1'b0, 20);
      check("both edge irq_second", n_irq2 - s2, 32'h2);
      check("both edge toggles", n_tog - st, 32'h2);
      rchk("second at fall", OFS_SECOND, 32'h1d);
      check("secondary captures irq", n_irq1 - s1, 32'h2);
      rchk("first at secondary fall", OFS_FIRST, 32'h27);
      // No primary edge: the counter wraps, each compare hits once
      cfg(4'h8, 3'h0, 3'h3, 6'h01, 16'h0, 16'hffff);
      repeat (65536) @(posedge clk);
      check("wrap irq_second", n_irq2 - s2, 32'h1);
      check("wrap irq_first", n_irq1 - s1, 32'h1);
      check("wrap toggle", n_tog - st, 32'h1);
      // Stop mode clears the counter and holds it
      wreg(OFS_MODE, 32'h0);
      repeat (10) @(posedge clk);
      rchk("count after stop", OFS_COUNT, 32'h0);
      check("toggle after stop", {31'h0, tog}, 32'h0);
      print_verdict;
   end
endmodule
